// ---- include/oad_pkg.sv ----
// How it works
// [RL1] Eight-bit index register, zero at reset, offsets every indexed mode.
// [RL2] Eight-bit stack pointer, zero at reset, names the top of stack.
// [RL3] Sixteen-bit program counter as high and low bytes, both zero at reset.
// [RL4] Immediate source: opcode picks A, flags, SP or X; two bytes long.
// [RL5] Direct source: second byte addresses RAM or register space; two bytes.
// [RL6] Indexed source: second byte plus X addresses the source; two bytes.
// [RL7] Direct or indexed source arithmetic uses opcode's A or X as second operand; the code feeds it in as first operand (opa).
// [RL8] Direct destination: second byte addresses result; A or X source; two bytes.
// [RL9] Indexed destination: second byte plus X; source always A; two bytes.
// [RL10] Destination arithmetic reads the destination first, then writes result back.
// [RL11] Direct destination immediate: byte two addresses, byte three literal; three bytes.
// [RL12] Indexed destination immediate: byte two plus X, byte three literal; three bytes.
// [RL13] Memory to memory mode only for copy: dest byte two, source byte three.
// [RL14] Flags bank bit picks register bank 0 or 1 for register-space accesses.
// [RL15] Core registers are not in register space; only instructions change them.
// [RL16] Indexed address is an 8-bit sum, carry out of bit 7 dropped.
// [RL17] RAM versus register space is decided from the opcode alone.
package oad_pkg;

  localparam int unsigned APB_AW = 8;

  // Register offsets, byte addresses
  localparam logic [APB_AW-1:0] OFS_INSTR  = 8'h00;
  localparam logic [APB_AW-1:0] OFS_CTRL   = 8'h04;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h08;
  localparam logic [APB_AW-1:0] OFS_CORE   = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_PC     = 8'h10;
  localparam logic [APB_AW-1:0] OFS_EADDR  = 8'h14;

  // Field positions
  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_ILL_BIT    = 1;
  localparam int unsigned FLG_ZERO_BIT    = 1;
  localparam int unsigned FLG_CARRY_BIT   = 2;
  localparam int unsigned FLG_SUPER_BIT   = 3;
  localparam int unsigned FLG_BANK_BIT    = 4;

  // Values after reset
  localparam logic [7:0]  RST_A     = 8'h00;
  localparam logic [7:0]  RST_F     = 8'h02;
  localparam logic [7:0]  RST_X     = 8'h00;
  localparam logic [7:0]  RST_SP    = 8'h00;
  localparam logic [7:0]  RST_PCH   = 8'h00;
  localparam logic [7:0]  RST_PCL   = 8'h00;
  localparam logic [23:0] RST_INSTR = 24'h000000;

  // Instruction lengths in bytes
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  typedef enum logic [3:0] {
    MODE_NONE     = 4'h0,
    MODE_IMM      = 4'h1,
    MODE_DIR      = 4'h2,
    MODE_IDX      = 4'h3,
    MODE_DDIR     = 4'h4,
    MODE_DIDX     = 4'h5,
    MODE_DDIR_IMM = 4'h6,
    MODE_DIDX_IMM = 4'h7,
    MODE_MEM2MEM  = 4'h8
  } oad_mode_t;

  typedef enum logic [2:0] {
    AOP_COPY = 3'h0,
    AOP_ADD  = 3'h1,
    AOP_OR   = 3'h2,
    AOP_XOR  = 3'h3,
    AOP_AND  = 3'h4
  } oad_aop_t;

  typedef enum logic [1:0] {
    REG_A  = 2'h0,
    REG_F  = 2'h1,
    REG_SP = 2'h2,
    REG_X  = 2'h3
  } oad_reg_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ADDR  = 2'h1,
    ST_READ  = 2'h2,
    ST_WRITE = 2'h3
  } oad_state_t;

endpackage

// ---- rtl/oad_alu.sv ----
`timescale 1ns/1ps
module oad_alu
  import oad_pkg::*;
(
  input  wire oad_aop_t   aop,
  input  wire logic [7:0] opa,
  input  wire logic [7:0] opb,
  output logic      [7:0] res,
  output logic            carry
);

  // A copy passes the new source through untouched
  always_comb begin
    res   = opb;
    carry = 1'b0;
    unique case (aop)
      AOP_COPY: res = opb;
      AOP_ADD: {carry, res} = {1'b0, opa} + {1'b0, opb};
      AOP_OR:  res = opa | opb;
      AOP_XOR: res = opa ^ opb;
      AOP_AND: res = opa & opb;
      default: res = opb;
    endcase
  end

endmodule // oad_alu

// ---- rtl/oad_decode.sv ----
`timescale 1ns/1ps
module oad_decode
  import oad_pkg::*;
(
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] operand,
  input  wire logic [7:0] index,
  output oad_mode_t       mode,
  output oad_aop_t        aop,
  output oad_reg_t        rsel,
  output logic            reg_space,
  output logic [1:0]      len,
  output logic            illegal,
  output logic [7:0]      ea
);

  logic idx_mode;

  always_comb begin
    mode      = MODE_NONE;
    aop       = AOP_COPY;
    rsel      = REG_A;
    reg_space = 1'b0;
    illegal   = 1'b0;
    // Arithmetic families share one mode map in the low three bits
    if ((opcode[7:3] == 5'h00 || opcode[7:3] == 5'h05 || opcode[7:3] == 5'h06)
        && opcode[2:0] != 3'h0) begin
      mode = oad_mode_t'({1'b0, opcode[2:0]});
      aop  = (opcode[7:3] == 5'h00) ? AOP_ADD :
             (opcode[7:3] == 5'h05) ? AOP_OR : AOP_XOR;
    end else begin
      unique case (opcode)
        8'h38: begin mode = MODE_IMM; aop = AOP_ADD; rsel = REG_SP; end // RL4
        8'h57: begin mode = MODE_IMM; rsel = REG_X; end // RL4
        8'h58: begin mode = MODE_DIR; rsel = REG_X; end // RL5
        8'h59: begin mode = MODE_IDX; rsel = REG_X; end // RL6
        8'h5A: begin mode = MODE_DDIR; rsel = REG_X; end // RL8
        8'h5D: begin mode = MODE_DIR; reg_space = 1'b1; end // RL17
        8'h5E: begin mode = MODE_IDX; reg_space = 1'b1; end // RL17
        8'h5F: mode = MODE_MEM2MEM; // RL13
        8'h60: begin mode = MODE_DDIR; reg_space = 1'b1; end // RL17
        8'h61: begin mode = MODE_DIDX; reg_space = 1'b1; end // RL9
        8'h62: begin mode = MODE_DDIR_IMM; reg_space = 1'b1; end // RL11
        8'h63: begin mode = MODE_DIDX_IMM; reg_space = 1'b1; end // RL12
        8'h70: begin mode = MODE_IMM; aop = AOP_AND; rsel = REG_F; end // RL4
        8'h71: begin mode = MODE_IMM; aop = AOP_OR; rsel = REG_F; end // RL4
        default: illegal = 1'b1;
      endcase
    end
  end

  assign idx_mode = (mode == MODE_IDX) || (mode == MODE_DIDX) || (mode == MODE_DIDX_IMM);
  // Carry out of bit 7 is dropped so the sum wraps
  assign ea  = idx_mode ? 8'(operand + index) : operand; // RL16 RL6 RL9 RL12
  assign len = (mode == MODE_DDIR_IMM || mode == MODE_DIDX_IMM || mode == MODE_MEM2MEM)
               ? LEN_THREE : LEN_TWO; // RL4 RL5 RL11 RL13

endmodule // oad_decode

// ---- rtl/oad_core.sv ----
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module oad_core
  import oad_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic                   mem_reg_space,
  output logic                   mem_bank,
  output logic      [7:0]        mem_addr,
  output logic      [7:0]        mem_wdata,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic              mem_ack,
  output logic                   busy
);

  oad_state_t  state_q;
  logic [23:0] instr_q;
  logic [7:0]  a_q;
  logic [7:0]  f_q;
  logic [7:0]  x_q;
  logic [7:0]  sp_q;
  logic [7:0]  pch_q;
  logic [7:0]  pcl_q;
  logic        ill_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        mem_req_q;
  logic        mem_we_q;
  logic        mem_space_q;
  logic        mem_bank_q;
  logic [7:0]  mem_addr_q;
  logic [7:0]  mem_wdata_q;
  logic [7:0]  ea_q;
  logic        busy_q;

  logic [7:0]  opcode;
  logic [7:0]  op1;
  logic [7:0]  op2;
  oad_mode_t   mode;
  oad_aop_t    aop;
  oad_reg_t    rsel;
  logic        reg_space;
  logic [1:0]  len;
  logic        illegal;
  logic [7:0]  ea;

  logic        apb_take;
  logic        apb_first;
  logic        hit;
  logic        wr_en;
  logic        start;
  logic        ill_clr;
  logic [31:0] rd_mux;

  logic        is_src;
  logic        is_dst;
  logic        imm_var;
  logic        need_read;
  logic        read_ack;
  logic        write_ack;
  logic [7:0]  reg_val;
  logic [7:0]  opa;
  logic [7:0]  opb;
  logic [7:0]  alu_res;
  logic        alu_carry;
  logic        reg_we;
  logic        flag_we;
  logic        finish;
  logic        fail;
  logic [15:0] pc_next;

  assign opcode = instr_q[7:0];
  assign op1    = instr_q[15:8];
  assign op2    = instr_q[23:16];

  // Decoder reads X live, so an index just written is used at once
  oad_decode u_decode (
    .opcode    (opcode),
    .operand   (op1),
    .index     (x_q),
    .mode      (mode),
    .aop       (aop),
    .rsel      (rsel),
    .reg_space (reg_space),
    .len       (len),
    .illegal   (illegal),
    .ea        (ea)
  );

  // One shared unit serves register and memory results alike
  oad_alu u_alu (
    .aop   (aop),
    .opa   (opa),
    .opb   (opb),
    .res   (alu_res),
    .carry (alu_carry)
  );

  // APB slave: one wait state so read data comes from a flop
  assign apb_first = psel & penable & ~pready_q;
  assign apb_take  = psel & penable & pready_q;
  // Unaligned or unlisted offsets miss and are refused
  assign hit       = (paddr == OFS_INSTR)  || (paddr == OFS_CTRL) ||
                     (paddr == OFS_STATUS) || (paddr == OFS_CORE) ||
                     (paddr == OFS_PC)     || (paddr == OFS_EADDR);
  assign wr_en     = apb_take & pwrite & hit;
  assign start     = wr_en & (paddr == OFS_CTRL) & pwdata[CTRL_START_BIT] &
                     (state_q == ST_IDLE);
  assign ill_clr   = wr_en & (paddr == OFS_STATUS) & pwdata[STAT_ILL_BIT];

  // Core registers are visible here read-only, never in the core's register space
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      OFS_INSTR:  rd_mux = {8'h00, instr_q};
      OFS_STATUS: rd_mux = {30'h00000000, ill_q, state_q != ST_IDLE};
      OFS_CORE:   rd_mux = {sp_q, x_q, f_q, a_q}; // RL15
      OFS_PC:     rd_mux = {16'h0000, pch_q, pcl_q};
      OFS_EADDR:  rd_mux = {22'h000000, mem_bank_q, mem_space_q, ea_q};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  // Ready and error are single-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_first;
      pslverr_q <= apb_first & ~hit;
      if (apb_first) begin
        prdata_q <= (pwrite || !hit) ? 32'h00000000 : rd_mux;
      end
    end
  end

  // Instruction bytes only change while idle; a write mid-run is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= RST_INSTR;
    end else if (wr_en && paddr == OFS_INSTR && state_q == ST_IDLE) begin
      instr_q <= pwdata[23:0];
    end
  end

  // Operand selection
  assign is_src    = (mode == MODE_IMM) || (mode == MODE_DIR) || (mode == MODE_IDX);
  assign is_dst    = (mode == MODE_DDIR) || (mode == MODE_DIDX) ||
                     (mode == MODE_DDIR_IMM) || (mode == MODE_DIDX_IMM);
  assign imm_var   = (mode == MODE_DDIR_IMM) || (mode == MODE_DIDX_IMM);
  // A plain copy into memory skips the destination read
  assign need_read = !(mode == MODE_IMM) && !(is_dst && aop == AOP_COPY);
  assign read_ack  = (state_q == ST_READ) & mem_req_q & mem_ack;
  assign write_ack = (state_q == ST_WRITE) & mem_req_q & mem_ack;

  // Register named by the opcode
  always_comb begin
    unique case (rsel)
      REG_A:   reg_val = a_q;
      REG_F:   reg_val = f_q;
      REG_SP:  reg_val = sp_q;
      REG_X:   reg_val = x_q;
      default: reg_val = a_q;
    endcase
  end

  // Destination modes feed the stored byte in as first operand
  assign opa = is_src ? reg_val : mem_rdata; // RL7 RL10
  assign opb = (mode == MODE_IMM) ? op1 :
               ((state_q == ST_READ) && (is_src || mode == MODE_MEM2MEM)) ? mem_rdata :
               imm_var ? op2 : reg_val; // RL4 RL11 RL12

  // Immediates retire in the address cycle, the rest on a memory ack
  assign fail    = (state_q == ST_ADDR) & illegal;
  assign reg_we  = ((state_q == ST_ADDR) & !illegal & (mode == MODE_IMM)) |
                   (read_ack & is_src); // RL4 RL5 RL6
  assign flag_we = (reg_we | (read_ack & is_dst)) & (aop != AOP_COPY) &
                   (rsel != REG_F) & (rsel != REG_SP);
  assign finish  = reg_we | write_ack;
  // Counter wraps at 16 bits
  assign pc_next = {pch_q, pcl_q} + {14'h0000, len};

  // Sequencer: decode, then an optional read and an optional write
  // Illegal codes go straight back to idle and leave the counter alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:  if (start) state_q <= ST_ADDR;
        ST_ADDR: begin
          if (illegal || mode == MODE_IMM) begin
            state_q <= ST_IDLE;
          end else if (need_read) begin
            state_q <= ST_READ;
          end else begin
            state_q <= ST_WRITE;
          end
        end
        ST_READ: begin
          if (read_ack) begin
            state_q <= is_src ? ST_IDLE : ST_WRITE; // RL10
          end
        end
        ST_WRITE: if (write_ack) state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Memory port; request drops a cycle between read and write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_space_q <= 1'b0;
      mem_bank_q  <= 1'b0;
      mem_addr_q  <= 8'h00;
      mem_wdata_q <= 8'h00;
      ea_q        <= 8'h00;
    end else begin
      if (state_q == ST_ADDR && !illegal && mode != MODE_IMM) begin
        ea_q        <= ea; // RL5 RL6 RL8 RL9
        mem_space_q <= reg_space; // RL17
        mem_bank_q  <= reg_space & f_q[FLG_BANK_BIT]; // RL14
        mem_req_q   <= need_read;
        mem_we_q    <= 1'b0;
        // Copy between RAM cells reads its source from byte three first
        mem_addr_q  <= (mode == MODE_MEM2MEM) ? op2 : ea; // RL13
        if (!need_read) begin
          mem_wdata_q <= alu_res; // RL8 RL11 RL12
        end
      end else if (read_ack) begin
        mem_req_q   <= 1'b0;
        mem_wdata_q <= alu_res; // RL10
        mem_addr_q  <= ea_q;
      // Write request rises only after the read request has dropped
      end else if (state_q == ST_WRITE && !mem_req_q) begin
        mem_req_q <= 1'b1;
        mem_we_q  <= 1'b1;
      end else if (write_ack) begin
        mem_req_q <= 1'b0;
        mem_we_q  <= 1'b0;
      end
    end
  end

  // Accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= RST_A;
    end else if (reg_we && rsel == REG_A) begin
      a_q <= alu_res; // RL15
    end
  end

  // Index register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_q <= RST_X; // RL1
    end else if (reg_we && rsel == REG_X) begin
      x_q <= alu_res; // RL1
    end
  end

  // Stack pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= RST_SP; // RL2
    end else if (reg_we && rsel == REG_SP) begin
      sp_q <= alu_res; // RL2
    end
  end

  // Flags; supervisor bit cannot be written, bits 7 to 5 stay zero, bit 0 takes the written value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_q <= RST_F;
    end else if (reg_we && rsel == REG_F) begin
      f_q <= {3'h0, alu_res[FLG_BANK_BIT], f_q[FLG_SUPER_BIT], alu_res[2:0]}; // RL14
    end else if (flag_we) begin
      f_q[FLG_ZERO_BIT]  <= (alu_res == 8'h00);
      f_q[FLG_CARRY_BIT] <= alu_carry;
    end
  end

  // Program counter advances by the instruction length when it retires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pch_q <= RST_PCH; // RL3
      pcl_q <= RST_PCL; // RL3
    end else if (finish) begin
      pch_q <= pc_next[15:8]; // RL3
      pcl_q <= pc_next[7:0]; // RL3
    end
  end

  // Sticky illegal flag; a new failure beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ill_q <= 1'b0;
    end else if (fail) begin
      ill_q <= 1'b1;
    end else if (ill_clr) begin
      ill_q <= 1'b0;
    end
  end

  // Busy pin from its own flop, so it never glitches on state decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (finish || fail) begin
      busy_q <= 1'b0;
    end
  end

  // Every pin below is a plain flop output
  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign mem_req       = mem_req_q;
  assign mem_we        = mem_we_q;
  assign mem_reg_space = mem_space_q;
  assign mem_bank      = mem_bank_q;
  assign mem_addr      = mem_addr_q;
  assign mem_wdata     = mem_wdata_q;
  assign busy          = busy_q;

endmodule // oad_core

// ---- bench/oad_core_asserts.sv ----
`timescale 1ns/1ps
module oad_core_asserts
  import oad_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_reg_space,
  input wire logic        mem_bank,
  input wire logic [7:0]  mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_ack,
  input wire logic        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (psel && penable && pready
    && (paddr > OFS_EADDR || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata) && $stable(mem_reg_space) && $stable(mem_bank))
    else $error("memory request changed before ack");
  mem_release_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request kept after ack");
  mem_busy_a: assert property (mem_req |-> busy)
    else $error("memory request while idle");
  bank_space_a: assert property (mem_req && !mem_reg_space |-> !mem_bank)
    else $error("bank set on a RAM access");
endmodule // oad_core_asserts

bind oad_core oad_core_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_reg_space(mem_reg_space),
  .mem_bank(mem_bank), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .busy(busy));

// ---- bench/oad_mem_model.sv ----
`timescale 1ns/1ps
module oad_mem_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       mem_req,
  input  wire logic       mem_we,
  input  wire logic       mem_reg_space,
  input  wire logic       mem_bank,
  input  wire logic [7:0] mem_addr,
  input  wire logic [7:0] mem_wdata,
  output logic      [7:0] mem_rdata,
  output logic            mem_ack
);
  logic [7:0] ram  [256];
  logic [7:0] reg0 [256];
  logic [7:0] reg1 [256];
  logic [1:0] wait_q;
  // Data toggles when not answering, so a stale byte never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      wait_q    <= 2'h0;
      mem_rdata <= 8'hA5;
    end else begin
      mem_rdata <= ~mem_rdata;
      if (mem_ack) begin
        mem_ack <= 1'b0;
        wait_q  <= 2'($urandom_range(3));
        if (mem_we && !mem_reg_space) ram[mem_addr] <= mem_wdata;
        else if (mem_we && mem_bank) reg1[mem_addr] <= mem_wdata;
        else if (mem_we) reg0[mem_addr] <= mem_wdata;
      end else if (mem_req && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (mem_req) begin
        mem_ack   <= 1'b1;
        mem_rdata <= !mem_reg_space ? ram[mem_addr] :
                     mem_bank ? reg1[mem_addr] : reg0[mem_addr];
      end
    end
  end
endmodule // oad_mem_model

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import oad_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, erv;
  logic        mem_req, mem_we, mem_reg_space, mem_bank, mem_ack;
  logic [7:0]  paddr, mem_addr, mem_wdata, mem_rdata, a, x, sp, f, b2, b3, ea, m;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] pc;
  logic [8:0]  s;
  int          fail_count = 0;
  int          tests_run = 0;

  oad_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_reg_space(mem_reg_space),
    .mem_bank(mem_bank), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));
  oad_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_reg_space(mem_reg_space), .mem_bank(mem_bank), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  function automatic logic [7:0] fl(input logic [7:0] fo, input logic [8:0] v);
    return {fo[7:3], v[8], v[7:0] == 8'h00, fo[0]};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) fail_count++;
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Shadows hold the expectation before each call
  task automatic exec(input logic [7:0] op, input logic [7:0] o2, input logic [7:0] o3);
    int n;
    n = 0;
    apb(1'b1, OFS_INSTR, {8'h00, o3, o2, op});
    apb(1'b1, OFS_CTRL, 32'h1);
    chk("busy run", 32'h1, {31'h0, busy});
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rdv[STAT_BUSY_BIT] !== 1'b0 && n < 50);
    if (n >= 50) fail_count++;
    chk("busy end", 32'h0, {31'h0, busy});
    apb(1'b0, OFS_CORE, 32'h0);
    chk("core", {sp, x, f, a}, rdv);
    apb(1'b0, OFS_PC, 32'h0);
    chk("pc", {16'h0, pc}, rdv);
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    void'($urandom(63643));
    for (int i = 0; i < 256; i++) begin
      u_mem.ram[i]  = 8'($urandom);
      u_mem.reg0[i] = 8'($urandom);
    end
    a  = RST_A;
    x  = RST_X;
    sp = RST_SP;
    f  = RST_F;
    pc = 16'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CORE, 32'h0);
    chk("core rst", {sp, x, f, a}, rdv);
    apb(1'b0, OFS_PC, 32'h0);
    chk("pc rst", 32'h0, rdv);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {31'h0, erv});
    apb(1'b1, OFS_CORE, 32'hFFFFFFFF);
    apb(1'b1, OFS_PC, 32'hFFFFFFFF);
    // Index near the top so indexed sums wrap
    x  = 8'hF0;
    pc = pc + 16'h2;
    exec(8'h57, x, 8'h00);
    b2 = 8'($urandom);
    sp = sp + b2;
    pc = pc + 16'h2;
    exec(8'h38, b2, 8'h00);
    b2 = 8'($urandom);
    s  = {1'b0, a} + {1'b0, b2};
    a  = s[7:0];
    f  = fl(f, s);
    pc = pc + 16'h2;
    exec(8'h01, b2, 8'h00);
    for (int k = 2; k < 8; k++) begin
      b2 = 8'($urandom) | 8'h80;
      b3 = 8'($urandom);
      ea = k[0] ? b2 + x : b2;
      m  = u_mem.ram[ea];
      s  = {1'b0, m} + {1'b0, k > 5 ? b3 : a};
      if (k < 4) a = s[7:0];
      f  = fl(f, s);
      pc = pc + (k > 5 ? 16'h3 : 16'h2);
      exec(8'(k), b2, b3);
      if (k > 3) chk("ram", {24'h0, s[7:0]}, {24'h0, u_mem.ram[ea]});
      apb(1'b0, OFS_EADDR, 32'h0);
      chk("eaddr", {24'h0, ea}, rdv);
    end
    b2 = 8'h11;
    b3 = 8'h22;
    m  = u_mem.ram[b3];
    pc = pc + 16'h3;
    exec(8'h5F, b2, b3);
    chk("copy", {24'h0, m}, {24'h0, u_mem.ram[b2]});
    f  = {3'h0, 1'b1, f[3:0]};
    pc = pc + 16'h2;
    exec(8'h71, 8'h10, 8'h00);
    b2 = 8'($urandom);
    pc = pc + 16'h2;
    exec(8'h60, b2, 8'h00);
    chk("bank1", {24'h0, a}, {24'h0, u_mem.reg1[b2]});
    apb(1'b0, OFS_EADDR, 32'h0);
    chk("eaddr reg", {22'h0, 2'h3, b2}, rdv);
    f  = {3'h0, 1'b0, f[3:0]};
    pc = pc + 16'h2;
    exec(8'h70, 8'hEF, 8'h00);
    b3 = 8'($urandom);
    pc = pc + 16'h3;
    exec(8'h62, b2, b3);
    chk("bank0", {24'h0, b3}, {24'h0, u_mem.reg0[b2]});
    // Register-space reads, indexed writes, OR/XOR and index moves
    ea = b2 + x;
    a  = u_mem.reg0[ea];
    pc = pc + 16'h2;
    exec(8'h5E, b2, 8'h00);
    a  = u_mem.reg0[b2];
    pc = pc + 16'h2;
    exec(8'h5D, b2, 8'h00);
    pc = pc + 16'h3;
    exec(8'h63, b2, b3);
    chk("reg idx imm", {24'h0, b3}, {24'h0, u_mem.reg0[ea]});
    pc = pc + 16'h2;
    exec(8'h61, b2, 8'h00);
    chk("reg idx", {24'h0, a}, {24'h0, u_mem.reg0[ea]});
    m  = u_mem.ram[b2];
    s  = {1'b0, a ^ m};
    a  = s[7:0];
    f  = fl(f, s);
    pc = pc + 16'h2;
    exec(8'h32, b2, 8'h00);
    s  = {1'b0, a | m};
    f  = fl(f, s);
    pc = pc + 16'h2;
    exec(8'h2C, b2, 8'h00);
    chk("or dst", {24'h0, s[7:0]}, {24'h0, u_mem.ram[b2]});
    ea = b2 + x;
    x  = u_mem.ram[ea];
    pc = pc + 16'h2;
    exec(8'h59, b2, 8'h00);
    x  = u_mem.ram[b2];
    pc = pc + 16'h2;
    exec(8'h58, b2, 8'h00);
    b3 = 8'($urandom);
    pc = pc + 16'h2;
    exec(8'h5A, b3, 8'h00);
    chk("dst x", {24'h0, x}, {24'h0, u_mem.ram[b3]});
    exec(8'hFF, 8'h00, 8'h00);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("illegal", 32'h2, rdv & 32'h3);
    apb(1'b1, OFS_STATUS, 32'h2);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("ill clear", 32'h0, rdv & 32'h3);
    // Second reset mid-run brings the core registers back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CORE, 32'h0);
    chk("core rst2", {RST_SP, RST_X, RST_F, RST_A}, rdv);
    apb(1'b0, OFS_PC, 32'h0);
    chk("pc rst2", {16'h0, RST_PCH, RST_PCL}, rdv);
    report_and_stop();
  end
endmodule // testbench
